// file: logic/clf_top.sv
// Control line function logic: heating gate, telegram trigger and analog setup.
//
// Summary of operation
// - An open control contact reads high through the internal pull-up.
// - A contact shorted to analog ground reads low.
// - A low control line requests SDI-12 mode.
// - With the function disabled the line level drives only the SDI-12 request.
// - Heating function forces heating off at the chosen level, else automatic.
// - Rising-edge setting starts one telegram per low-to-high transition.
// - Falling-edge setting starts one telegram per high-to-low transition.
// - Level settings transmit telegrams while the line holds the chosen level.
// - Heating control works in both duplex modes; telegram control only full duplex.
// - Half duplex never sends telegrams autonomously.
// - Half duplex ignores every telegram trigger setting.
// - Half duplex keeps heating control, analog output and SDI-12.
// - The serial port selects half duplex two-wire or full duplex four-wire.
// - Analog outputs run only with the binary protocol selected.
// - Output A offers current, voltage or 2 to 2000 Hz frequency modes.
// - Output B offers current and voltage modes only.
// - Outputs default to channels 400 and 500; channels are configurable.
`timescale 1ns/100ps
module clf_top
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_ctrl_line,
  input  wire logic [3:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  output logic                   o_heat_off,
  output logic                   o_tel_start,
  output logic                   o_tel_hold,
  output logic                   o_sdi_req,
  output logic                   o_full_duplex,
  output clf_pkg::clf_analog_s   o_analog
);

  // ==========================================================================
  // Synchronised control line
  // ==========================================================================
  logic line_lvl;
  logic line_rise;
  logic line_fall;

  // The pad pull-up makes an open contact read high; the block sees only
  // the resolved level, so an undriven line is high by construction.
  clf_sync u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_async   (i_ctrl_line),
    .o_level   (line_lvl),
    .o_rise    (line_rise),
    .o_fall    (line_fall)
  );

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    clf_pkg::clf_func_e  func;
    logic                pol_high;
    logic                fdx;
    clf_pkg::clf_proto_e proto;
    clf_pkg::clf_amode_e mode_a;
    clf_pkg::clf_amode_e mode_b;
    logic [10:0]         freq_a;
    logic [15:0]         chan_a;
    logic [15:0]         chan_b;
    logic [31:0]         rdata;
    clf_pkg::clf_act_s   act;
    clf_pkg::clf_analog_s analog;
  } clf_state_s;

  clf_state_s st;
  clf_state_s next_st;

  // Legal function codes only; an illegal write keeps the previous function.
  function automatic logic func_ok(input logic [2:0] code);
    func_ok = (code <= 3'b101);
  endfunction

  function automatic logic [10:0] clamp_freq(input logic [10:0] f);
    if (f < clf_pkg::FREQ_MIN)
      clamp_freq = clf_pkg::FREQ_MIN;
    else if (f > clf_pkg::FREQ_MAX)
      clamp_freq = clf_pkg::FREQ_MAX;
    else
      clamp_freq = f;
  endfunction

  logic [2:0] wr_func;
  logic [2:0] wr_proto;
  logic [2:0] wr_ma;
  logic [2:0] wr_mb;

  assign wr_func  = i_wdata[clf_pkg::CTRL_FUNC_LSB +: 3];
  assign wr_proto = i_wdata[clf_pkg::CTRL_PROTO_LSB +: 3];
  assign wr_ma    = i_wdata[clf_pkg::AN_A_MODE_LSB +: 3];
  assign wr_mb    = i_wdata[clf_pkg::AN_B_MODE_LSB +: 3];

  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    // ========================================================================
    // Register writes
    // ========================================================================
    if (i_wr)
    begin
      case (i_addr)
        clf_pkg::ADDR_CTRL:
        begin
          if (func_ok(wr_func))
            next_st.func = clf_pkg::clf_func_e'(wr_func);
          next_st.pol_high = i_wdata[clf_pkg::CTRL_POL_BIT];
          next_st.fdx      = i_wdata[clf_pkg::CTRL_FDX_BIT];
          if (wr_proto <= 3'b101)
            next_st.proto = clf_pkg::clf_proto_e'(wr_proto);
        end
        clf_pkg::ADDR_ANALOG:
        begin
          if (wr_ma <= 3'b100)
            next_st.mode_a = clf_pkg::clf_amode_e'(wr_ma);
          if (wr_mb <= 3'b011)
            next_st.mode_b = clf_pkg::clf_amode_e'(wr_mb);
          next_st.freq_a = clamp_freq(i_wdata[clf_pkg::AN_A_FREQ_LSB +: 11]);
        end
        clf_pkg::ADDR_CHAN:
        begin
          next_st.chan_a = i_wdata[clf_pkg::CHAN_A_LSB +: 16];
          next_st.chan_b = i_wdata[clf_pkg::CHAN_B_LSB +: 16];
        end
        default:
        begin
        end
      endcase
    end
    // ========================================================================
    // Register reads
    // ========================================================================
    if (i_rd)
    begin
      case (i_addr)
        clf_pkg::ADDR_CTRL:
          next_st.rdata = {24'h00_0000, st.proto, st.fdx, st.pol_high, st.func};
        clf_pkg::ADDR_ANALOG:
          next_st.rdata = {13'h0000, st.freq_a, 1'b0, st.mode_b, 1'b0, st.mode_a};
        clf_pkg::ADDR_CHAN:
          next_st.rdata = {st.chan_b, st.chan_a};
        clf_pkg::ADDR_STATUS:
          next_st.rdata = {27'h000_0000, line_lvl, st.act};
        default:
          next_st.rdata = 32'h0000_0000;
      endcase
    end
    // ========================================================================
    // Control line actions
    // ========================================================================
    next_st.act.heat_off  = 1'b0;
    next_st.act.tel_pulse = 1'b0;
    next_st.act.tel_hold  = 1'b0;
    next_st.act.sdi_req   = ~line_lvl;
    case (st.func)
      clf_pkg::CLF_FUNC_OFF:
      begin
      end
      // Heating works regardless of duplex mode.
      clf_pkg::CLF_FUNC_HEAT:
        next_st.act.heat_off = (line_lvl == st.pol_high);
      // Telegram triggers need full duplex; half duplex answers requests only.
      clf_pkg::CLF_FUNC_RISE:
        next_st.act.tel_pulse = st.fdx & line_rise;
      clf_pkg::CLF_FUNC_FALL:
        next_st.act.tel_pulse = st.fdx & line_fall;
      clf_pkg::CLF_FUNC_HIGH:
        next_st.act.tel_hold = st.fdx & line_lvl;
      clf_pkg::CLF_FUNC_LOW:
        next_st.act.tel_hold = st.fdx & ~line_lvl;
      default:
      begin
      end
    endcase
    // ========================================================================
    // Analog output setup
    // ========================================================================
    next_st.analog.enable = (st.proto == clf_pkg::CLF_PROTO_BIN);
    next_st.analog.mode_a = st.mode_a;
    next_st.analog.mode_b = st.mode_b;
    next_st.analog.freq_a = st.freq_a;
    next_st.analog.chan_a = st.chan_a;
    next_st.analog.chan_b = st.chan_b;
  end

  // Factory state: function disabled, binary protocol, half duplex.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st          <= '0;
      st.func     <= clf_pkg::CLF_FUNC_OFF;
      st.proto    <= clf_pkg::CLF_PROTO_BIN;
      st.mode_a   <= clf_pkg::RST_AMODE;
      st.mode_b   <= clf_pkg::RST_AMODE;
      st.freq_a   <= clf_pkg::FREQ_MIN;
      st.chan_a   <= clf_pkg::RST_CHAN_A;
      st.chan_b   <= clf_pkg::RST_CHAN_B;
      // The outputs show the factory channel setup during reset already; only
      // the enable waits for the first edge, so nothing is driven too early.
      st.analog.mode_a <= clf_pkg::RST_AMODE;
      st.analog.mode_b <= clf_pkg::RST_AMODE;
      st.analog.freq_a <= clf_pkg::FREQ_MIN;
      st.analog.chan_a <= clf_pkg::RST_CHAN_A;
      st.analog.chan_b <= clf_pkg::RST_CHAN_B;
    end
    else
      st <= next_st;
  end

  assign o_rdata       = st.rdata;
  assign o_heat_off    = st.act.heat_off;
  assign o_tel_start   = st.act.tel_pulse;
  assign o_tel_hold    = st.act.tel_hold;
  assign o_sdi_req     = st.act.sdi_req;
  assign o_full_duplex = st.fdx;
  assign o_analog      = st.analog;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  off_quiet_a: assert property (
    st.func == clf_pkg::CLF_FUNC_OFF |=> !o_heat_off && !o_tel_start && !o_tel_hold)
    else $error("disabled line acts");
  heat_pol_a: assert property (
    st.func == clf_pkg::CLF_FUNC_HEAT
    |=> o_heat_off == ($past(line_lvl) == $past(st.pol_high)))
    else $error("heat gate");
  heat_func_a: assert property (
    st.func != clf_pkg::CLF_FUNC_HEAT |=> !o_heat_off)
    else $error("heat gate outside heating function");
  rise_tel_a: assert property (
    st.func == clf_pkg::CLF_FUNC_RISE && st.fdx && line_rise |=> o_tel_start)
    else $error("rise missed");
  fall_tel_a: assert property (
    st.func == clf_pkg::CLF_FUNC_FALL && st.fdx && line_fall |=> o_tel_start)
    else $error("fall missed");
  edge_only_a: assert property (
    !line_rise && !line_fall |=> !o_tel_start)
    else $error("start without an edge");
  level_tel_a: assert property (
    st.func == clf_pkg::CLF_FUNC_LOW && st.fdx && !line_lvl |=> o_tel_hold)
    else $error("low hold missed");
  high_tel_a: assert property (
    st.func == clf_pkg::CLF_FUNC_HIGH && st.fdx && line_lvl |=> o_tel_hold)
    else $error("high hold missed");
  hold_stop_a: assert property (
    (st.func == clf_pkg::CLF_FUNC_HIGH && !line_lvl)
    || (st.func == clf_pkg::CLF_FUNC_LOW && line_lvl) |=> !o_tel_hold)
    else $error("hold outside level");
  half_tel_a: assert property (
    !st.fdx ##1 !$past(st.fdx) |-> !o_tel_start && !o_tel_hold)
    else $error("half duplex sent");
  heat_half_a: assert property (
    st.func == clf_pkg::CLF_FUNC_HEAT && !st.fdx && line_lvl == st.pol_high
    |=> o_heat_off) else $error("half heat");
  one_func_a: assert property (
    !(o_heat_off && (o_tel_start || o_tel_hold)) && !(o_tel_start && o_tel_hold))
    else $error("two functions at once");
  sdi_low_a: assert property (!line_lvl |=> o_sdi_req) else $error("sdi request");
  sdi_high_a: assert property (line_lvl |=> !o_sdi_req) else $error("idle sdi");
  analog_bin_a: assert property (
    st.proto != clf_pkg::CLF_PROTO_BIN |=> !o_analog.enable) else $error("analog on");
  analog_on_a: assert property (
    st.proto == clf_pkg::CLF_PROTO_BIN |=> o_analog.enable) else $error("analog off");
  b_no_freq_a: assert property (st.mode_b != clf_pkg::CLF_AMODE_FREQ)
    else $error("B in frequency mode");
  freq_range_a: assert property (
    st.freq_a >= clf_pkg::FREQ_MIN && st.freq_a <= clf_pkg::FREQ_MAX)
    else $error("frequency out of range");
  ctrl_rd_a: assert property (
    i_rd && i_addr == clf_pkg::ADDR_CTRL |=> o_rdata[2:0] == $past(st.func))
    else $error("function readback");
  status_rd_a: assert property (
    i_rd && i_addr == clf_pkg::ADDR_STATUS |=> o_rdata[4] == $past(line_lvl))
    else $error("line level readback");

  cov_rise_c: cover property (o_tel_start);
  cov_sdi_c: cover property (o_sdi_req ##1 !o_sdi_req);
  cov_hold_c: cover property (o_tel_hold [*3]);
  cov_heat_c: cover property (o_heat_off ##1 !o_heat_off);
  cov_half_c: cover property (!st.fdx && line_rise && st.func == clf_pkg::CLF_FUNC_RISE);

endmodule

// file: logic/clf_pkg.sv
// Package of constants and types for the control line function block.
package clf_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_ANALOG = 4'h1;
  localparam logic [3:0] ADDR_CHAN   = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // CTRL fields.
  localparam int CTRL_FUNC_LSB  = 0;
  localparam int CTRL_POL_BIT   = 3;
  localparam int CTRL_FDX_BIT   = 4;
  localparam int CTRL_PROTO_LSB = 5;

  // ANALOG fields.
  localparam int AN_A_MODE_LSB = 0;
  localparam int AN_B_MODE_LSB = 4;
  localparam int AN_A_FREQ_LSB = 8;

  // CHAN fields.
  localparam int CHAN_A_LSB = 0;
  localparam int CHAN_B_LSB = 16;

  // ==========================================================================
  // Reset values and frequency limits
  // ==========================================================================
  localparam logic [15:0] RST_CHAN_A = 16'h0190;
  localparam logic [15:0] RST_CHAN_B = 16'h01f4;
  localparam logic [10:0] FREQ_MIN   = 11'h002;
  localparam logic [10:0] FREQ_MAX   = 11'h7d0;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    CLF_FUNC_OFF  = 3'b000,
    CLF_FUNC_HEAT = 3'b001,
    CLF_FUNC_RISE = 3'b010,
    CLF_FUNC_FALL = 3'b011,
    CLF_FUNC_HIGH = 3'b100,
    CLF_FUNC_LOW  = 3'b101
  } clf_func_e;

  typedef enum logic [2:0] {
    CLF_PROTO_BIN    = 3'b000,
    CLF_PROTO_ASCII  = 3'b001,
    CLF_PROTO_NMEA   = 3'b010,
    CLF_PROTO_SDI    = 3'b011,
    CLF_PROTO_MB_RTU = 3'b100,
    CLF_PROTO_MB_ASC = 3'b101
  } clf_proto_e;

  typedef enum logic [2:0] {
    CLF_AMODE_I0_20  = 3'b000,
    CLF_AMODE_I4_20  = 3'b001,
    CLF_AMODE_V0_10  = 3'b010,
    CLF_AMODE_V2_10  = 3'b011,
    CLF_AMODE_FREQ   = 3'b100
  } clf_amode_e;

  localparam clf_amode_e RST_AMODE = CLF_AMODE_I4_20;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } clf_bus_s;

  typedef struct packed {
    logic       heat_off;
    logic       tel_pulse;
    logic       tel_hold;
    logic       sdi_req;
  } clf_act_s;

  typedef struct packed {
    logic       enable;
    clf_amode_e mode_a;
    clf_amode_e mode_b;
    logic [10:0] freq_a;
    logic [15:0] chan_a;
    logic [15:0] chan_b;
  } clf_analog_s;

endpackage

// file: logic/clf_sync.sv
// Two-stage synchroniser with edge detection for the control input.
`timescale 1ns/100ps
module clf_sync
(
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
    logic fall;
  } clf_sync_s;

  clf_sync_s st;
  clf_sync_s next_st;

  // Idle level is high: the pull-up holds an open contact at one.
  always_comb
  begin
    next_st      = st;
    next_st.meta = i_async;
    next_st.sync = st.meta;
    next_st.last = st.sync;
    next_st.rise = st.sync & ~st.last;
    next_st.fall = ~st.sync & st.last;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      st <= '{meta: 1'b1, sync: 1'b1, last: 1'b1, rise: 1'b0, fall: 1'b0};
    else
      st <= next_st;
  end

  assign o_level = st.sync;
  assign o_rise  = st.rise;
  assign o_fall  = st.fall;

  single_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    st.rise |=> !st.rise) else $error("two rises from one transition");

endmodule

// file: bench/clf_contact_model.sv
// Volt-free switching contact between the control input and analog ground.
`timescale 1ns/100ps
module clf_contact_model
(
  input  wire logic i_closed,
  output logic      o_line
);
  // ==========================================================================
  // Contact
  // ==========================================================================
  // The open contact leaves the pad to the pull-up, so the line rests high.
  // A closed contact holds the line low, which also asks for SDI-12 mode.
  assign o_line = i_closed ? 1'b0 : 1'b1;
endmodule

// file: bench/control_line_function_logic_tb.sv
// Self-checking testbench for the control line function block.
`timescale 1ns/100ps
module control_line_function_logic_tb;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 closed = 1'b0;
  logic                 line;
  logic [3:0]           addr = 4'h0;
  logic [31:0]          wdata = 32'h0;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic [31:0]          rdata;
  logic                 heat_off;
  logic                 tel_start;
  logic                 tel_hold;
  logic                 sdi_req;
  logic                 fdx;
  clf_pkg::clf_analog_s analog;
  int                   mismatches = 0;
  int                   total_checks = 0;
  int                   pulses = 0;

  always #2 clk = ~clk;

  clf_contact_model contact (.i_closed(closed), .o_line(line));

  clf_top DUT
  (
    .i_clk_sys     (clk),
    .i_resetn      (rst_n),
    .i_ctrl_line   (line),
    .i_addr        (addr),
    .i_wdata       (wdata),
    .i_wr          (wr),
    .i_rd          (rd),
    .o_rdata       (rdata),
    .o_heat_off    (heat_off),
    .o_tel_start   (tel_start),
    .o_tel_hold    (tel_hold),
    .o_sdi_req     (sdi_req),
    .o_full_duplex (fdx),
    .o_analog      (analog)
  );

  // The start output is a one-cycle pulse, so every edge has to be counted.
  always @(posedge clk)
  begin
    if (tel_start === 1'b1)
      pulses++;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] f, input logic p, input logic x,
                                       input logic [2:0] pr);
    return ({29'h0, f} << clf_pkg::CTRL_FUNC_LSB) | ({31'h0, p} << clf_pkg::CTRL_POL_BIT)
         | ({31'h0, x} << clf_pkg::CTRL_FDX_BIT) | ({29'h0, pr} << clf_pkg::CTRL_PROTO_LSB);
  endfunction

  task automatic set_line(input logic lvl);
    @(posedge clk);
    closed <= ~lvl;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic reset_state();
    logic [31:0] d;
    chk({31'h0, sdi_req}, 32'h0);
    chk({31'h0, analog.enable}, 32'h1);
    chk({29'h0, analog.mode_a}, {29'h0, clf_pkg::RST_AMODE});
    bus_rd(clf_pkg::ADDR_CHAN, d);
    chk(d, {clf_pkg::RST_CHAN_B, clf_pkg::RST_CHAN_A});
    chk({16'h0, analog.chan_b}, 32'h1f4);
  endtask

  // Walks off, heating and both level settings through every polarity,
  // duplex mode and line level.
  task automatic level_functions();
    logic [2:0] f;
    logic       eh;
    logic       et;
    for (int i = 0; i < 4; i++)
    begin
      f = (i < 2) ? i[2:0] : i[2:0] + 3'h2;
      for (int m = 0; m < 4; m++)
      begin
        bus_wr(clf_pkg::ADDR_CTRL, ctrl(f, m[0], m[1], 3'h0));
        for (int l = 0; l < 2; l++)
        begin
          set_line(l[0]);
          eh = (f == 3'h1) && (l[0] == m[0]);
          et = m[1] && (((f == 3'h4) && l[0]) || ((f == 3'h5) && !l[0]));
          chk({31'h0, heat_off}, {31'h0, eh});
          chk({31'h0, tel_hold}, {31'h0, et});
          chk({31'h0, sdi_req}, {31'h0, !l[0]});
          chk({31'h0, fdx}, {31'h0, m[1]});
        end
      end
    end
  endtask

  task automatic edge_functions();
    logic [2:0] f;
    for (int i = 0; i < 4; i++)
    begin
      f = i[1] ? clf_pkg::CLF_FUNC_FALL : clf_pkg::CLF_FUNC_RISE;
      set_line(1'b1);
      bus_wr(clf_pkg::ADDR_CTRL, ctrl(f, 1'b0, i[0], 3'h0));
      repeat (4) @(posedge clk);
      pulses = 0;
      set_line(1'b0);
      chk(pulses, {31'h0, i[0] && i[1]});
      pulses = 0;
      set_line(1'b1);
      chk(pulses, {31'h0, i[0] && !i[1]});
      chk({31'h0, tel_hold}, 32'h0);
    end
  endtask

  task automatic config_checks();
    logic [31:0] d;
    bus_wr(clf_pkg::ADDR_ANALOG, 32'h0007_ff44);
    bus_wr(clf_pkg::ADDR_CHAN, 32'h1234_5678);
    repeat (2) @(posedge clk);
    chk({29'h0, analog.mode_a}, {29'h0, clf_pkg::CLF_AMODE_FREQ});
    chk({29'h0, analog.mode_b}, {29'h0, clf_pkg::RST_AMODE});
    chk({21'h0, analog.freq_a}, {21'h0, clf_pkg::FREQ_MAX});
    chk({analog.chan_b, analog.chan_a}, 32'h1234_5678);
    bus_wr(clf_pkg::ADDR_ANALOG, 32'h0000_0033);
    repeat (2) @(posedge clk);
    chk({21'h0, analog.freq_a}, {21'h0, clf_pkg::FREQ_MIN});
    chk({29'h0, analog.mode_b}, 32'h3);
    bus_wr(clf_pkg::ADDR_CTRL, ctrl(3'h2, 1'b0, 1'b1, 3'h1));
    bus_wr(clf_pkg::ADDR_CTRL, ctrl(3'h7, 1'b0, 1'b1, 3'h1));
    repeat (2) @(posedge clk);
    chk({31'h0, analog.enable}, 32'h0);
    bus_rd(clf_pkg::ADDR_CTRL, d);
    chk(d & 32'h7, 32'h2);
    bus_rd(4'h9, d);
    chk(d, 32'h0);
    // Open contact, rising-edge function with no transition: only the level bit.
    bus_rd(clf_pkg::ADDR_STATUS, d);
    chk(d, 32'h10);
  endtask

  // ==========================================================================
  // Closing
  // ==========================================================================
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    reset_state();
    level_functions();
    edge_functions();
    config_checks();
    give_verdict();
  end
endmodule
